// ==== eiapc_top.sv ====
// external interrupt and extended priority controller with apb registers
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - priority one bit 5: comparator interrupt low when 0, high when 1
// - priority one bit 4: counter array interrupt priority
// - priority one bit 3: converter conversion-complete interrupt priority
// - priority one bit 2: converter window-comparator interrupt priority
// - priority one bit 1: port match interrupt priority
// - priority one bit 0: smbus interrupt priority
// - priority two bit 1: capsense greater-than interrupt priority
// - priority two bit 0: capsense conversion-complete interrupt priority
// - each external input has its own polarity bit
// - each external input has a type bit: level or edge
// - type/polarity pairs give falling, rising, low-level, high-level sensing
// - pin sampled directly, never disturbing peripheral routed there
// - skip bit set keeps crossbar from routing any peripheral to pin
// - pending flags sit at timer control bits 1 and 3
// - edge mode: edge sets pending, vectoring clears it
// - level mode: pending reads active level of the input
// - 3-bit select picks port 0 pin 0 to 7 per input
module eiapc_top (
  input wire logic CLK, // system clock 100 MHz
  input wire logic RST_B, // async reset, active low
  input wire logic [11:0] PADDR, // apb byte address
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb write
  input wire logic [31:0] PWDATA, // apb write data
  input wire logic [3:0] PSTRB, // apb byte strobes
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error, unmapped address
  input wire logic [7:0] PORT0_PINS, // port 0 pin levels
  input wire logic [7:0] PERIPH_REQ, // peripheral requests, vectors 2 to 9
  input wire logic [1:0] EXT_BASE_HIGH, // base priority of ext a and b
  input wire logic CPU_ACK, // cpu vectors to IRQ_VECTOR
  input wire logic CPU_RETI, // cpu ends current routine
  output logic IRQ_REQ, // interrupt request to cpu
  output logic [3:0] IRQ_VECTOR, // vector number requested
  output logic IRQ_HIGH, // request is high priority
  output logic [7:0] XBAR_SKIP // pins the crossbar must skip
);
  // ==========================================================================
  // reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ==========================================================================
  // apb decode
  typedef enum logic [4:0] {
    SEL_NONE = 5'h00,
    SEL_PRIO_ONE = 5'h01,
    SEL_PRIO_TWO = 5'h02,
    SEL_EXT_CFG = 5'h04,
    SEL_TIMER_CTL = 5'h08,
    SEL_XBAR_SKIP = 5'h10
  } eiapc_sel_e;

  function automatic eiapc_sel_e decode(input logic [11:0] addr);
    eiapc_sel_e s;
    s = SEL_NONE;
    case (addr)
      eiapc_pkg::ADDR_PRIO_ONE: s = SEL_PRIO_ONE;
      eiapc_pkg::ADDR_PRIO_TWO: s = SEL_PRIO_TWO;
      eiapc_pkg::ADDR_EXT_CFG: s = SEL_EXT_CFG;
      eiapc_pkg::ADDR_TIMER_CTL: s = SEL_TIMER_CTL;
      eiapc_pkg::ADDR_XBAR_SKIP: s = SEL_XBAR_SKIP;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction : decode

  logic setup;
  logic access;
  logic wr;
  eiapc_sel_e sel_acc;
  eiapc_sel_e sel_set;

  always_comb begin
    setup = PSEL & ~PENABLE;
    access = PSEL & PENABLE;
    sel_acc = decode(PADDR);
    sel_set = decode(PADDR);
    wr = access & PWRITE & PSTRB[0];
  end

  // zero wait states: every access completes in its first access cycle
  assign PREADY = 1'b1;
  assign PSLVERR = access & (sel_acc == SEL_NONE);

  // ==========================================================================
  // registers
  logic [7:0] prio_one_q;
  logic [7:0] prio_one_d;
  logic [7:0] prio_two_q;
  logic [7:0] prio_two_d;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [1:0] type_q;
  logic [1:0] type_d;
  logic [7:0] skip_q;
  logic [7:0] skip_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [1:0] pend;
  logic [7:0] tctl_rd;

  always_comb begin
    prio_one_d = prio_one_q;
    prio_two_d = prio_two_q;
    cfg_d = cfg_q;
    type_d = type_q;
    skip_d = skip_q;
    if (wr) begin
      case (sel_acc)
        SEL_PRIO_ONE: prio_one_d = PWDATA[7:0] & eiapc_pkg::PRIO_ONE_MASK;
        SEL_PRIO_TWO: prio_two_d = PWDATA[7:0] & eiapc_pkg::PRIO_TWO_MASK;
        SEL_EXT_CFG: cfg_d = PWDATA[7:0];
        SEL_TIMER_CTL: begin
          type_d[0] = PWDATA[eiapc_pkg::TCTL_A_TYPE];
          type_d[1] = PWDATA[eiapc_pkg::TCTL_B_TYPE];
        end
        SEL_XBAR_SKIP: skip_d = PWDATA[7:0];
        default: skip_d = skip_q;
      endcase
    end
  end

  always_comb begin
    tctl_rd = 8'h00;
    tctl_rd[eiapc_pkg::TCTL_A_TYPE] = type_q[0];
    tctl_rd[eiapc_pkg::TCTL_A_PEND] = pend[0];
    tctl_rd[eiapc_pkg::TCTL_B_TYPE] = type_q[1];
    tctl_rd[eiapc_pkg::TCTL_B_PEND] = pend[1];
    prdata_d = prdata_q;
    // read data is captured in the setup cycle so PRDATA is a flop output
    if (setup && !PWRITE) begin
      case (sel_set)
        SEL_PRIO_ONE: prdata_d = {24'h000000, prio_one_q & eiapc_pkg::PRIO_ONE_MASK};
        SEL_PRIO_TWO: prdata_d = {24'h000000, prio_two_q & eiapc_pkg::PRIO_TWO_MASK};
        SEL_EXT_CFG: prdata_d = {24'h000000, cfg_q};
        SEL_TIMER_CTL: prdata_d = {24'h000000, tctl_rd};
        SEL_XBAR_SKIP: prdata_d = {24'h000000, skip_q};
        default: prdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      prio_one_q <= eiapc_pkg::RST_PRIO_ONE;
      prio_two_q <= eiapc_pkg::RST_PRIO_TWO;
      cfg_q <= eiapc_pkg::RST_EXT_CFG;
      type_q <= {eiapc_pkg::RST_TIMER_CTL[eiapc_pkg::TCTL_B_TYPE], eiapc_pkg::RST_TIMER_CTL[eiapc_pkg::TCTL_A_TYPE]};
      skip_q <= eiapc_pkg::RST_XBAR_SKIP;
      prdata_q <= 32'h00000000;
    end else begin
      prio_one_q <= prio_one_d;
      prio_two_q <= prio_two_d;
      cfg_q <= cfg_d;
      type_q <= type_d;
      skip_q <= skip_d;
      prdata_q <= prdata_d;
    end
  end

  assign PRDATA = prdata_q;
  assign XBAR_SKIP = skip_q;

  // ==========================================================================
  // external inputs
  eiapc_arb_if arb_bus ();

  logic [2:0] ext_sel [2];
  logic [1:0] ext_pol;
  logic [1:0] ext_pin;
  logic [1:0] ext_ack;
  logic [1:0] ext_swv;
  logic tctl_wr;

  always_comb begin
    ext_sel[0] = cfg_q[eiapc_pkg::CFG_A_SEL_LSB +: 3];
    ext_sel[1] = cfg_q[eiapc_pkg::CFG_B_SEL_LSB +: 3];
    ext_pol[0] = cfg_q[eiapc_pkg::CFG_A_POL];
    ext_pol[1] = cfg_q[eiapc_pkg::CFG_B_POL];
    ext_swv[0] = PWDATA[eiapc_pkg::TCTL_A_PEND];
    ext_swv[1] = PWDATA[eiapc_pkg::TCTL_B_PEND];
    tctl_wr = wr & (sel_acc == SEL_TIMER_CTL);
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ext
      // the pin is only observed, so a peripheral routed there keeps it
      assign ext_pin[g] = PORT0_PINS[ext_sel[g]];
      assign ext_ack[g] = CPU_ACK & arb_bus.irq & (arb_bus.vec == 4'(g));
      eiapc_ext_det u_det (
        .clk(CLK),
        .rst_n(rst_n),
        .pin(ext_pin[g]),
        .polarity(ext_pol[g]),
        .edge_mode(type_q[g]),
        .vec_ack(ext_ack[g]),
        .sw_wr(tctl_wr),
        .sw_val(ext_swv[g]),
        .pending(pend[g])
      );
    end
  endgenerate

  // ==========================================================================
  // request and priority vectors
  always_comb begin
    arb_bus.req = {PERIPH_REQ, pend[1], pend[0]};
    arb_bus.high[eiapc_pkg::VEC_EXT_A] = EXT_BASE_HIGH[0];
    arb_bus.high[eiapc_pkg::VEC_EXT_B] = EXT_BASE_HIGH[1];
    arb_bus.high[eiapc_pkg::VEC_COMPARATOR] = prio_one_q[eiapc_pkg::P1_COMPARATOR];
    arb_bus.high[eiapc_pkg::VEC_COUNTER_ARRAY] = prio_one_q[eiapc_pkg::P1_COUNTER_ARRAY];
    arb_bus.high[eiapc_pkg::VEC_CONV_DONE] = prio_one_q[eiapc_pkg::P1_CONV_DONE];
    arb_bus.high[eiapc_pkg::VEC_CONV_WINDOW] = prio_one_q[eiapc_pkg::P1_CONV_WINDOW];
    arb_bus.high[eiapc_pkg::VEC_PORT_MATCH] = prio_one_q[eiapc_pkg::P1_PORT_MATCH];
    arb_bus.high[eiapc_pkg::VEC_SMBUS] = prio_one_q[eiapc_pkg::P1_SMBUS];
    arb_bus.high[eiapc_pkg::VEC_CAPSENSE_GREATER] = prio_two_q[eiapc_pkg::P2_CAPSENSE_GREATER];
    arb_bus.high[eiapc_pkg::VEC_CAPSENSE_DONE] = prio_two_q[eiapc_pkg::P2_CAPSENSE_DONE];
    arb_bus.ack = CPU_ACK;
    arb_bus.reti = CPU_RETI;
  end

  // a level source still active after its routine simply requests again
  eiapc_arb u_arb (
    .clk(CLK),
    .rst_n(rst_n),
    .bus(arb_bus)
  );

  assign IRQ_REQ = arb_bus.irq;
  assign IRQ_VECTOR = arb_bus.vec;
  assign IRQ_HIGH = arb_bus.vec_high;

  // ==========================================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence s_read_setup(logic [11:0] a);
    PSEL && !PENABLE && !PWRITE && PADDR == a;
  endsequence

  a_prio_two_zero: assert property (s_read_setup(eiapc_pkg::ADDR_PRIO_TWO) |=> PRDATA[31:2] == 30'h00000000)
    else $error("reserved priority two bits not zero");
  a_prio_one_zero: assert property (prio_one_q[7:6] == 2'h0)
    else $error("reserved priority one bits not zero");
  a_comp_prio_map: assert property (wr && sel_acc == SEL_PRIO_ONE |=> arb_bus.high[2] == $past(PWDATA[5]))
    else $error("comparator priority does not follow bit 5");
  a_smb_prio_map: assert property (wr && sel_acc == SEL_PRIO_ONE |=> arb_bus.high[7] == $past(PWDATA[0]))
    else $error("smbus priority does not follow bit 0");
  a_cs_prio_map: assert property (wr && sel_acc == SEL_PRIO_TWO |=> arb_bus.high[8] == $past(PWDATA[1]))
    else $error("capsense greater priority does not follow bit 1");
  a_pend_readback: assert property (s_read_setup(eiapc_pkg::ADDR_TIMER_CTL) |=> PRDATA[3] == $past(pend[1])
                                    && PRDATA[1] == $past(pend[0]))
    else $error("pending flags not at bits 1 and 3");
  a_unmapped_err: assert property (access && sel_acc == SEL_NONE |-> PSLVERR && PREADY)
    else $error("unmapped access not flagged");
  a_skip_output: assert property (wr && sel_acc == SEL_XBAR_SKIP |=> XBAR_SKIP == $past(PWDATA[7:0]))
    else $error("skip mask not driven");

  // each priority bit steers only its own source into the arbiter
  a_cnt_prio_map: assert property (wr && sel_acc == SEL_PRIO_ONE |=> arb_bus.high[3] == $past(PWDATA[4]))
    else $error("counter array priority does not follow bit 4");
  a_done_prio_map: assert property (wr && sel_acc == SEL_PRIO_ONE |=> arb_bus.high[4] == $past(PWDATA[3]))
    else $error("conversion done priority does not follow bit 3");
  a_win_prio_map: assert property (wr && sel_acc == SEL_PRIO_ONE |=> arb_bus.high[5] == $past(PWDATA[2]))
    else $error("window priority does not follow bit 2");
  a_match_prio_map: assert property (wr && sel_acc == SEL_PRIO_ONE |=> arb_bus.high[6] == $past(PWDATA[1]))
    else $error("port match priority does not follow bit 1");
  a_csd_prio_map: assert property (wr && sel_acc == SEL_PRIO_TWO |=> arb_bus.high[9] == $past(PWDATA[0]))
    else $error("capsense done priority does not follow bit 0");
  a_prio_two_resv: assert property (prio_two_q[7:2] == 6'h00)
    else $error("reserved priority two bits hold ones");
  a_prdata_holds: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
    else $error("read data changed outside a read setup");
  a_ack_drops_req: assert property (CPU_ACK && IRQ_REQ |=> !IRQ_REQ)
    else $error("request still raised after vectoring");
  a_vec_in_range: assert property (IRQ_REQ |-> int'(IRQ_VECTOR) < eiapc_pkg::NUM_VEC)
    else $error("request vector out of range");
endmodule : eiapc_top
`default_nettype wire

// ==== eiapc_pkg.sv ====
// constants and types shared by the external interrupt and priority controller
package eiapc_pkg;

  // ==========================================================================
  // register indices (byte address = 4 * index) and reset values
  localparam logic [7:0] IDX_PRIO_ONE = 8'hF3;
  localparam logic [7:0] IDX_PRIO_TWO = 8'hF4;
  localparam logic [7:0] IDX_EXT_CFG = 8'hE4;
  localparam logic [7:0] IDX_TIMER_CTL = 8'hF5;
  localparam logic [7:0] IDX_XBAR_SKIP = 8'hF6;
  localparam logic [11:0] ADDR_PRIO_ONE = {2'h0, IDX_PRIO_ONE, 2'h0};
  localparam logic [11:0] ADDR_PRIO_TWO = {2'h0, IDX_PRIO_TWO, 2'h0};
  localparam logic [11:0] ADDR_EXT_CFG = {2'h0, IDX_EXT_CFG, 2'h0};
  localparam logic [11:0] ADDR_TIMER_CTL = {2'h0, IDX_TIMER_CTL, 2'h0};
  localparam logic [11:0] ADDR_XBAR_SKIP = {2'h0, IDX_XBAR_SKIP, 2'h0};
  localparam logic [7:0] RST_PRIO_ONE = 8'h00;
  localparam logic [7:0] RST_PRIO_TWO = 8'h00;
  localparam logic [7:0] RST_EXT_CFG = 8'h01;
  localparam logic [7:0] RST_TIMER_CTL = 8'h00;
  localparam logic [7:0] RST_XBAR_SKIP = 8'h00;
  localparam logic [7:0] PRIO_ONE_MASK = 8'h3F;
  localparam logic [7:0] PRIO_TWO_MASK = 8'h03;

  // ==========================================================================
  // field positions
  localparam int P1_COMPARATOR = 5;
  localparam int P1_COUNTER_ARRAY = 4;
  localparam int P1_CONV_DONE = 3;
  localparam int P1_CONV_WINDOW = 2;
  localparam int P1_PORT_MATCH = 1;
  localparam int P1_SMBUS = 0;
  localparam int P2_CAPSENSE_GREATER = 1;
  localparam int P2_CAPSENSE_DONE = 0;
  localparam int CFG_A_SEL_LSB = 0;
  localparam int CFG_A_POL = 3;
  localparam int CFG_B_SEL_LSB = 4;
  localparam int CFG_B_POL = 7;
  localparam int TCTL_A_TYPE = 0;
  localparam int TCTL_A_PEND = 1;
  localparam int TCTL_B_TYPE = 2;
  localparam int TCTL_B_PEND = 3;

  // ==========================================================================
  // vector numbers, lower number wins inside one level
  localparam int NUM_VEC = 10;
  localparam int VEC_EXT_A = 0;
  localparam int VEC_EXT_B = 1;
  localparam int VEC_COMPARATOR = 2;
  localparam int VEC_COUNTER_ARRAY = 3;
  localparam int VEC_CONV_DONE = 4;
  localparam int VEC_CONV_WINDOW = 5;
  localparam int VEC_PORT_MATCH = 6;
  localparam int VEC_SMBUS = 7;
  localparam int VEC_CAPSENSE_GREATER = 8;
  localparam int VEC_CAPSENSE_DONE = 9;

  typedef logic [NUM_VEC-1:0] eiapc_vec_t;
  typedef logic [3:0] eiapc_idx_t;

  // service level: which priority levels are currently in service
  typedef enum logic [3:0] {
    LVL_IDLE = 4'h1,
    LVL_LOW = 4'h2,
    LVL_HIGH = 4'h4,
    LVL_BOTH = 4'h8
  } eiapc_lvl_e;

endpackage : eiapc_pkg

// ==== eiapc_arb_if.sv ====
// request and vectoring signals between the register core and the arbiter
`timescale 1ns/1ns
`default_nettype none
interface eiapc_arb_if;
  eiapc_pkg::eiapc_vec_t req;
  eiapc_pkg::eiapc_vec_t high;
  logic ack;
  logic reti;
  logic irq;
  eiapc_pkg::eiapc_idx_t vec;
  logic vec_high;

  modport ctrl (output req, output high, output ack, output reti, input irq, input vec, input vec_high);
  modport arb (input req, input high, input ack, input reti, output irq, output vec, output vec_high);
endinterface : eiapc_arb_if
`default_nettype wire

// ==== eiapc_ext_det.sv ====
// one external interrupt input: polarity, edge or level sensing, pending flag
`timescale 1ns/1ns
`default_nettype none
module eiapc_ext_det (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset
  input wire logic pin, // selected port pin level
  input wire logic polarity, // 1 active high
  input wire logic edge_mode, // 1 edge, 0 level
  input wire logic vec_ack, // cpu vectors to this source
  input wire logic sw_wr, // software writes the flag
  input wire logic sw_val, // value written
  output logic pending // pending flag
);
  logic act;
  logic rise;
  logic act_prev_q;
  logic pend_q;
  logic pend_d;

  // ==========================================================================
  // sensing
  always_comb begin
    act = polarity ? pin : ~pin;
    rise = act & ~act_prev_q;
    pend_d = pend_q;
    if (!edge_mode) begin
      pend_d = act;
    end else if (rise) begin
      pend_d = 1'b1;
    end else if (sw_wr) begin
      pend_d = sw_val;
    end else if (vec_ack) begin
      pend_d = 1'b0;
    end
  end

  // previous level resets active so a pin already asserted gives no edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_prev_q <= 1'b1;
      pend_q <= 1'b0;
    end else begin
      act_prev_q <= act;
      pend_q <= pend_d;
    end
  end

  assign pending = pend_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_edge_sets_flag: assert property (edge_mode && rise |=> pending)
    else $error("active edge did not set pending");
  a_ack_clears_flag: assert property (edge_mode && vec_ack && !rise && !sw_wr |=> !pending)
    else $error("vectoring did not clear edge pending");
  a_level_follows_pin: assert property (!edge_mode |=> pending == $past(act))
    else $error("level pending does not follow active level");
endmodule : eiapc_ext_det
`default_nettype wire

// ==== eiapc_arb.sv ====
// two-level priority arbiter with preemption of low by high
`timescale 1ns/1ns
`default_nettype none
module eiapc_arb (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset
  eiapc_arb_if.arb bus // requests in, vector out
);
  eiapc_pkg::eiapc_lvl_e lvl_q;
  eiapc_pkg::eiapc_lvl_e lvl_d;
  eiapc_pkg::eiapc_vec_t hi_p;
  eiapc_pkg::eiapc_vec_t lo_p;
  logic irq_q;
  logic irq_d;
  eiapc_pkg::eiapc_idx_t vec_q;
  eiapc_pkg::eiapc_idx_t vec_d;
  logic vh_q;
  logic vh_d;
  logic take;

  function automatic eiapc_pkg::eiapc_idx_t first_set(input eiapc_pkg::eiapc_vec_t v);
    eiapc_pkg::eiapc_idx_t r;
    r = 4'h0;
    for (int i = eiapc_pkg::NUM_VEC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : first_set

  // ==========================================================================
  // selection and service level
  always_comb begin
    hi_p = bus.req & bus.high;
    lo_p = bus.req & ~bus.high;
    take = bus.ack & irq_q;
    irq_d = 1'b0;
    vec_d = vec_q;
    vh_d = vh_q;
    lvl_d = lvl_q;
    case (lvl_q)
      eiapc_pkg::LVL_IDLE: begin
        if (|hi_p) begin
          irq_d = 1'b1;
          vec_d = first_set(hi_p);
          vh_d = 1'b1;
        end else if (|lo_p) begin
          irq_d = 1'b1;
          vec_d = first_set(lo_p);
          vh_d = 1'b0;
        end
      end
      eiapc_pkg::LVL_LOW: begin
        if (|hi_p) begin
          irq_d = 1'b1;
          vec_d = first_set(hi_p);
          vh_d = 1'b1;
        end
      end
      default: irq_d = 1'b0;
    endcase
    // flag clears one cycle late, so no request right after an ack
    if (take) begin
      irq_d = 1'b0;
      lvl_d = (lvl_q == eiapc_pkg::LVL_IDLE && !vh_q) ? eiapc_pkg::LVL_LOW :
              (lvl_q == eiapc_pkg::LVL_LOW) ? eiapc_pkg::LVL_BOTH : eiapc_pkg::LVL_HIGH;
    end else if (bus.reti) begin
      case (lvl_q)
        eiapc_pkg::LVL_BOTH: lvl_d = eiapc_pkg::LVL_LOW;
        eiapc_pkg::LVL_HIGH: lvl_d = eiapc_pkg::LVL_IDLE;
        eiapc_pkg::LVL_LOW: lvl_d = eiapc_pkg::LVL_IDLE;
        default: lvl_d = eiapc_pkg::LVL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= eiapc_pkg::LVL_IDLE;
      irq_q <= 1'b0;
      vec_q <= 4'h0;
      vh_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      irq_q <= irq_d;
      vec_q <= vec_d;
      vh_q <= vh_d;
    end
  end

  assign bus.irq = irq_q;
  assign bus.vec = vec_q;
  assign bus.vec_high = vh_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_take_high;
    bus.ack && irq_q && vh_q;
  endsequence
  sequence s_take_low;
    bus.ack && irq_q && !vh_q && lvl_q == eiapc_pkg::LVL_IDLE;
  endsequence

  a_high_blocks_all: assert property ((lvl_q == eiapc_pkg::LVL_HIGH || lvl_q == eiapc_pkg::LVL_BOTH) |-> !irq_q)
    else $error("request raised during high service");
  a_low_only_high: assert property (lvl_q == eiapc_pkg::LVL_LOW && irq_q |-> vh_q)
    else $error("low request raised during low service");
  a_high_enters_srv: assert property (s_take_high |=> lvl_q == eiapc_pkg::LVL_HIGH || lvl_q == eiapc_pkg::LVL_BOTH)
    else $error("high vectoring did not enter high service");
  a_low_enters_srv: assert property (s_take_low |=> lvl_q == eiapc_pkg::LVL_LOW ##1 !irq_q || vh_q)
    else $error("low vectoring did not enter low service");
  a_high_wins_low: assert property (lvl_q == eiapc_pkg::LVL_IDLE && |hi_p && !take |=> irq_q && vh_q)
    else $error("high request not chosen first");
endmodule : eiapc_arb
`default_nettype wire

// ==== eiapc_src.sv ====
// model of an external interrupt source on a port 0 pin
`timescale 1ns/1ns
`default_nettype none
module eiapc_src (
  input wire logic clk, // system clock
  input wire logic fire, // start a request
  input wire logic [2:0] sel, // pin that carries it
  input wire logic act, // active level
  input wire logic ack, // request recognised
  input wire logic [7:0] idle, // idle pin levels
  output logic [7:0] pins // port 0 pin levels
);
  logic hold_q = 1'b0;
  always @(posedge clk) begin
    if (fire) begin
      hold_q <= 1'b1;
    end else if (ack) begin
      hold_q <= 1'b0;
    end
  end
  // released pins fall back to their idle level
  always_comb begin
    pins = idle;
    if (hold_q) begin
      pins[sel] = act;
    end
  end
endmodule : eiapc_src
`default_nettype wire

// ==== eiapc_top_tb.sv ====
// self-checking testbench of the external interrupt and priority controller
`timescale 1ns/1ns
`default_nettype none
module eiapc_top_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq_req, irq_high, cpu_ack, cpu_reti, fire, act;
  logic [3:0] irq_vector;
  logic [7:0] pins, periph_req, xbar_skip;
  logic [2:0] sel;
  logic [31:0] r;
  logic e;
  int n_fail = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  initial begin
    {cpu_ack, cpu_reti, fire, act, sel, periph_req} = '0;
  end
  eiapc_src src (.clk(clk), .fire(fire), .sel(sel), .act(act), .ack(cpu_ack), .idle(8'h80), .pins(pins));
  eiapc_top DUT (.CLK(clk), .RST_B(rst_b), .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PORT0_PINS(pins),
    .PERIPH_REQ(periph_req), .EXT_BASE_HIGH(2'h0), .CPU_ACK(cpu_ack), .CPU_RETI(cpu_reti), .IRQ_REQ(irq_req),
    .IRQ_VECTOR(irq_vector), .IRQ_HIGH(irq_high), .XBAR_SKIP(xbar_skip));
  // ==========================================================================
  // bus and check helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulse(input logic is_ack);
    @(posedge clk);
    if (is_ack) cpu_ack <= 1'b1;
    else cpu_reti <= 1'b1;
    @(posedge clk);
    cpu_ack <= 1'b0;
    cpu_reti <= 1'b0;
  endtask : pulse
  task automatic test_done;
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // ==========================================================================
  // scenarios
  task automatic t_regs;
    apb(0, eiapc_pkg::ADDR_PRIO_ONE, 8'h00);
    chk(r, 32'h00);
    apb(1, eiapc_pkg::ADDR_PRIO_ONE, 8'hFF);
    apb(0, eiapc_pkg::ADDR_PRIO_ONE, 8'h00);
    chk(r, 32'h3F);
    apb(1, eiapc_pkg::ADDR_PRIO_TWO, 8'hFF);
    apb(0, eiapc_pkg::ADDR_PRIO_TWO, 8'h00);
    chk(r, 32'h03);
    apb(0, 12'h000, 8'h00);
    chk({r[30:0], e}, 32'h1);
    apb(1, eiapc_pkg::ADDR_XBAR_SKIP, 8'h08);
    @(posedge clk);
    chk(xbar_skip, 32'h08);
  endtask : t_regs
  // ext a rising edge on pin 3, ext b low level on pin 7
  task automatic t_edge_level;
    apb(1, eiapc_pkg::ADDR_TIMER_CTL, 8'h01);
    apb(1, eiapc_pkg::ADDR_EXT_CFG, 8'h7B);
    apb(1, eiapc_pkg::ADDR_TIMER_CTL, 8'h01);
    apb(0, eiapc_pkg::ADDR_TIMER_CTL, 8'h00);
    chk(r, 32'h01);
    @(posedge clk);
    fire <= 1'b1;
    sel <= 3'h3;
    act <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
    chk({irq_req, irq_vector}, 32'h10);
    apb(0, eiapc_pkg::ADDR_TIMER_CTL, 8'h00);
    chk(r, 32'h03);
    pulse(1);
    apb(0, eiapc_pkg::ADDR_TIMER_CTL, 8'h00);
    chk(r, 32'h01);
    pulse(0);
    @(posedge clk);
    fire <= 1'b1;
    sel <= 3'h7;
    act <= 1'b0;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
    chk({irq_req, irq_vector}, 32'h11);
    apb(0, eiapc_pkg::ADDR_TIMER_CTL, 8'h00);
    chk(r, 32'h09);
    pulse(1);
    apb(0, eiapc_pkg::ADDR_TIMER_CTL, 8'h00);
    chk(r, 32'h01);
    pulse(0);
  endtask : t_edge_level
  // ext a falling edge on pin 7, ext b high level on pin 3
  task automatic t_modes;
    apb(1, eiapc_pkg::ADDR_EXT_CFG, 8'hB7);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      fire <= 1'b1;
      sel <= (k == 0) ? 3'h7 : 3'h3;
      act <= (k == 0) ? 1'b0 : 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (3) @(posedge clk);
      chk({irq_req, irq_vector}, 32'h10 + k);
      pulse(1);
      pulse(0);
    end
  endtask : t_modes
  // each peripheral source alone at high level must beat all the others
  task automatic t_prio;
    @(posedge clk);
    periph_req <= 8'hFF;
    for (int i = 0; i < 8; i++) begin
      apb(1, eiapc_pkg::ADDR_PRIO_ONE, (i < 6) ? 8'h01 << (5 - i) : 8'h00);
      apb(1, eiapc_pkg::ADDR_PRIO_TWO, (i < 6) ? 8'h00 : 8'h01 << (7 - i));
      repeat (3) @(posedge clk);
      chk({irq_high, irq_vector}, 32'h12 + i);
    end
    apb(1, eiapc_pkg::ADDR_PRIO_TWO, 8'h00);
    repeat (3) @(posedge clk);
    chk({irq_high, irq_vector}, 32'h02);
    periph_req <= 8'h00;
  endtask : t_prio
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_edge_level();
    t_modes();
    t_prio();
    test_done();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule : eiapc_top_tb
`default_nettype wire
